// ===== logic/rx_dma_pkg.sv
// shared constants and carriers for the receive dma read channel
package rx_dma_pkg;

  // layout of the receive dma read configuration register
  localparam int CfgWidth      = 8;
  localparam int SelWidth      = 3;
  localparam int ByteWidth     = 8;
  localparam logic [SelWidth-1:0] SelChannel0 = 3'h0;
  localparam logic [CfgWidth-1:0] CfgResetVal = 8'h00;

  // default internal buffer depth in bytes
  localparam int BufDepthDefault = 128;

  typedef struct packed {
    logic                readChannelReset;   // bit 7
    logic                readChannelEnable;  // bit 6
    logic                readType;           // bit 5
    logic [1:0]          reserved;           // bits 4:3
    logic [SelWidth-1:0] readChannelSelect;  // bits 2:0
  } rx_dma_cfg_t;

  // one received byte from the hdlc receiver, last marks end of message
  typedef struct packed {
    logic                 last;
    logic [ByteWidth-1:0] data;
  } msg_word_t;

  // read type: strobe on the read pin, or strobe on the write pin
  typedef enum logic {
    ReadStrobe    = 1'b0,
    ReadDirection = 1'b1
  } read_type_t;

endpackage

// ===== logic/hdlc_rx_buffer_ram.sv
// small buffer memory holding received message bytes, registered read
module hdlc_rx_buffer_ram
  import rx_dma_pkg::*;
#(
  parameter int Depth = BufDepthDefault,
  parameter int AddrWidth = $clog2(Depth)
) (
  // clock
  input  wire logic                 mclk,
  // write port
  input  wire logic                 writeEn,
  input  wire logic [AddrWidth-1:0] writeAddr,
  input  wire msg_word_t            writeData,
  // read port
  input  wire logic [AddrWidth-1:0] readAddr,
  output msg_word_t                 readData
);

  msg_word_t mem [Depth];

  // no reset on the array so it maps to plain ram
  // a read of the word being written returns the new word, so a one-byte
  // message can leave in the cycle right after it arrives
  always_ff @(posedge mclk) begin
    if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
    if (writeEn && writeAddr == readAddr) begin
      readData <= writeData;
    end else begin
      readData <= mem[readAddr];
    end
  end

endmodule

// ===== logic/receive_dma_read_channel.sv
// receive dma read channel: hdlc receive buffer to external memory
//
// How it works
// - A zero-to-one reset bit flushes the channel; steady zero runs on.
// - Enable bit one turns the read interface on, zero turns it off.
// - While enabled, request only when a complete message is buffered.
// - Bytes only flow from the receive buffer toward external memory.
// - Each read transfer begins by pulling the active-low request low.
// - In strobe mode each low read strobe outputs a new byte.
// - In direction mode each low write strobe outputs a new byte.
// - Read type zero: read pin strobes; one: write pin strobes.
// - The three-bit select picks the channel; only code 000 is served.
// - All configuration bits come out of reset at zero.
module receive_dma_read_channel
  import rx_dma_pkg::*;
#(
  parameter int BufDepth = BufDepthDefault
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // configuration register port
  input  wire logic                 cfgWrite,
  input  wire logic [CfgWidth-1:0]  cfgWriteData,
  output logic      [CfgWidth-1:0]  cfgReadData,
  // bytes from the hdlc receiver
  input  wire logic                 msgValid,
  input  wire msg_word_t            msgWord,
  output logic                      msgReady,
  // dma handshake and bus strobes
  output logic                      read_dma_request_n,
  input  wire logic                 read_dma_acknowledge_n,
  input  wire logic                 readStrobe_n,
  input  wire logic                 writeStrobe_n,
  // data bus, two signals of the two-way pin
  output logic      [ByteWidth-1:0] busDataOut,
  output logic                      busDataOe_n,
  // status
  output logic                      messageWaiting
);

  localparam int AddrWidth = $clog2(BufDepth);
  localparam int PtrWidth  = AddrWidth + 1;
  localparam logic [PtrWidth-1:0] PtrOne   = PtrWidth'(1);
  localparam logic [PtrWidth-1:0] PtrDepth = PtrWidth'(BufDepth);

  if (BufDepth < 2 || (1 << AddrWidth) != BufDepth) begin : gDepthCheck
    $error("BufDepth must be a power of two and at least 2");
  end

  // storage for configuration fields
  rx_dma_cfg_t cfg_r;
  rx_dma_cfg_t cfg_nxt;
  logic [CfgWidth-1:0] cfgReadData_r;
  logic [CfgWidth-1:0] cfgReadData_nxt;

  // buffer pointers and complete message count
  logic [PtrWidth-1:0] wrPtr_r;
  logic [PtrWidth-1:0] wrPtr_nxt;
  logic [PtrWidth-1:0] rdPtr_r;
  logic [PtrWidth-1:0] rdPtr_nxt;
  logic [PtrWidth-1:0] msgCount_r;
  logic [PtrWidth-1:0] msgCount_nxt;
  logic                msgReady_r;
  logic                msgReady_nxt;

  // bus side state
  logic                 reqN_r;
  logic                 reqN_nxt;
  logic                 strobePrev_r;
  logic                 strobePrev_nxt;
  logic [ByteWidth-1:0] busData_r;
  logic [ByteWidth-1:0] busData_nxt;
  logic                 busOeN_r;
  logic                 busOeN_nxt;
  logic                 waiting_r;
  logic                 waiting_nxt;

  // combinational helpers
  rx_dma_cfg_t cfgIn;
  msg_word_t   ramReadData;
  logic        chanFlush;
  logic        pushByte;
  logic        popByte;
  logic        strobeLow;
  logic        strobeFall;
  logic        served;
  logic [PtrWidth-1:0] fill;

  // reserved bits are masked so they always read back zero
  function automatic rx_dma_cfg_t cleanCfg(input logic [CfgWidth-1:0] raw);
    rx_dma_cfg_t c;
    c = rx_dma_cfg_t'(raw);
    c.reserved = '0;
    return c;
  endfunction

  hdlc_rx_buffer_ram #(
    .Depth    (BufDepth),
    .AddrWidth(AddrWidth)
  ) uBuffer (
    .mclk     (mclk),
    .writeEn  (pushByte),
    .writeAddr(wrPtr_r[AddrWidth-1:0]),
    .writeData(msgWord),
    .readAddr (rdPtr_nxt[AddrWidth-1:0]),
    .readData (ramReadData)
  );

  // configuration register and channel flush
  always_comb begin
    cfgIn           = cleanCfg(cfgWriteData);
    cfg_nxt         = cfg_r;
    chanFlush       = 1'b0;
    if (cfgWrite) begin
      cfg_nxt = cfgIn;
      // only the rising edge flushes, a held one does nothing more
      chanFlush = cfgIn.readChannelReset
                  && !cfg_r.readChannelReset;
    end
    cfgReadData_nxt = CfgWidth'(cfg_nxt);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r         <= rx_dma_cfg_t'(CfgResetVal);
      cfgReadData_r <= CfgResetVal;
    end else begin
      cfg_r         <= cfg_nxt;
      cfgReadData_r <= cfgReadData_nxt;
    end
  end

  // strobe selection: read pin or write pin depending on read type
  always_comb begin
    unique case (read_type_t'(cfg_r.readType))
      ReadStrobe:    strobeLow = !readStrobe_n;
      ReadDirection: strobeLow = !writeStrobe_n;
    endcase
    // data only moves once the controller has acknowledged, so host
    // cycles to other registers never pop a byte
    strobeLow  = strobeLow && !read_dma_acknowledge_n && !reqN_r;
    strobeFall = strobeLow && !strobePrev_r;
  end

  // buffer fill, drain and request logic
  always_comb begin
    served       = cfg_r.readChannelEnable
                   && (cfg_r.readChannelSelect == SelChannel0);
    pushByte     = msgValid && msgReady_r;
    // a pop never starts on a partial message
    popByte      = served && strobeFall && (msgCount_r != '0);
    wrPtr_nxt    = wrPtr_r;
    rdPtr_nxt    = rdPtr_r;
    msgCount_nxt = msgCount_r;
    busData_nxt  = busData_r;
    if (pushByte) begin
      wrPtr_nxt = wrPtr_r + PtrOne;
    end
    if (popByte) begin
      rdPtr_nxt   = rdPtr_r + PtrOne;
      busData_nxt = ramReadData.data;
    end
    // a message ending and one leaving in one cycle keep the count level
    case ({pushByte && msgWord.last, popByte && ramReadData.last})
      2'b10:   msgCount_nxt = msgCount_r + PtrOne;
      2'b01:   msgCount_nxt = msgCount_r - PtrOne;
      default: msgCount_nxt = msgCount_r;
    endcase
    if (chanFlush) begin
      wrPtr_nxt    = '0;
      rdPtr_nxt    = '0;
      msgCount_nxt = '0;
    end
    // full check kept one byte early since ready is registered
    fill           = wrPtr_nxt - rdPtr_nxt;
    msgReady_nxt   = !chanFlush && (fill < (PtrDepth - PtrOne));
    waiting_nxt    = msgCount_nxt != '0;
    // the request drops in the flush cycle so no stale byte is offered
    reqN_nxt       = !(served && !chanFlush
                       && waiting_nxt);
    strobePrev_nxt = strobeLow;
    // the pin is driven only while the controller strobes a read
    busOeN_nxt     = !(served && strobeLow);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r      <= '0;
      rdPtr_r      <= '0;
      msgCount_r   <= '0;
      msgReady_r   <= 1'b0;
      reqN_r       <= 1'b1;
      strobePrev_r <= 1'b0;
      busData_r    <= '0;
      busOeN_r     <= 1'b1;
      waiting_r    <= 1'b0;
    end else begin
      wrPtr_r      <= wrPtr_nxt;
      rdPtr_r      <= rdPtr_nxt;
      msgCount_r   <= msgCount_nxt;
      msgReady_r   <= msgReady_nxt;
      reqN_r       <= reqN_nxt;
      strobePrev_r <= strobePrev_nxt;
      busData_r    <= busData_nxt;
      busOeN_r     <= busOeN_nxt;
      waiting_r    <= waiting_nxt;
    end
  end

  assign cfgReadData        = cfgReadData_r;
  assign msgReady           = msgReady_r;
  assign read_dma_request_n = reqN_r;
  assign busDataOut         = busData_r;
  assign busDataOe_n        = busOeN_r;
  assign messageWaiting     = waiting_r;

endmodule

// ===== dv/rx_dma_read_monitor.sv
// port assertions for the receive dma read channel
module rx_dma_read_monitor
  import rx_dma_pkg::*;
(
  // clock, reset, configuration
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire logic                 cfgWrite,
  input wire logic [CfgWidth-1:0]  cfgWriteData,
  input wire logic [CfgWidth-1:0]  cfgReadData,
  // receiver side
  input wire logic                 msgValid,
  input wire msg_word_t            msgWord,
  input wire logic                 msgReady,
  input wire logic                 messageWaiting,
  // dma side
  input wire logic                 read_dma_request_n,
  input wire logic                 read_dma_acknowledge_n,
  input wire logic                 readStrobe_n,
  input wire logic                 writeStrobe_n,
  input wire logic [ByteWidth-1:0] busDataOut,
  input wire logic                 busDataOe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // the live strobe follows the stored read type
  wire logic strobeN = cfgReadData[5] ? writeStrobe_n : readStrobe_n;
  wire logic popCond = !read_dma_acknowledge_n && !read_dma_request_n
                       && !strobeN;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence flushDone;
    !msgReady && read_dma_request_n ##1 msgReady;
  endsequence
  a_cfg_readback: assert property (
    cfgWrite |=> cfgReadData == ($past(cfgWriteData) & 8'hE7))
    else $error("config readback wrong");
  a_reset_values: assert property (
    $rose(rst_n) |-> cfgReadData == 8'h00 && read_dma_request_n)
    else $error("state after reset wrong");
  a_flush_empties: assert property (
    cfgWrite && cfgWriteData[7] && !cfgReadData[7] |=> flushDone)
    else $error("flush did not empty the channel");
  a_req_cause: assert property (
    $fell(read_dma_request_n) |-> messageWaiting && cfgReadData[6]
      && cfgReadData[2:0] == 3'h0)
    else $error("request without cause");
  a_off_quiet: assert property (
    !cfgReadData[6] |=> read_dma_request_n)
    else $error("request while disabled");
  a_pop_cause: assert property (
    $fell(busDataOe_n) |-> $past(popCond))
    else $error("bus driven without strobe");
  a_oe_release: assert property (
    !busDataOe_n && strobeN |=> busDataOe_n)
    else $error("bus not released");
  a_data_hold: assert property (
    !$fell(busDataOe_n) && !$past(cfgWrite) |-> $stable(busDataOut))
    else $error("bus data changed without pop");
  a_last_waits: assert property (
    msgValid && msgReady && msgWord.last |=> messageWaiting)
    else $error("complete message not flagged");
endmodule

bind receive_dma_read_channel rx_dma_read_monitor mon (
  .mclk(mclk), .rst_n(rst_n), .cfgWrite(cfgWrite),
  .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
  .msgValid(msgValid), .msgWord(msgWord), .msgReady(msgReady),
  .messageWaiting(messageWaiting), .read_dma_request_n(read_dma_request_n),
  .read_dma_acknowledge_n(read_dma_acknowledge_n),
  .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
  .busDataOut(busDataOut), .busDataOe_n(busDataOe_n));

// ===== dv/dma_ctrl_model.sv
// behavioural external dma controller draining the read channel
module dma_ctrl_model
  import rx_dma_pkg::*;
(
  // device side
  input  wire logic                 mclk,
  input  wire logic                 reqN,
  input  wire logic [ByteWidth-1:0] busData,
  input  wire logic                 busOe_n,
  // behaviour chosen by the bench
  input  wire logic                 dirMode,
  input  wire logic [3:0]           ackDelay,
  // handshake back to the device
  output logic                      ack_n,
  output logic                      rd_n,
  output logic                      wr_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ByteWidth-1:0] got[$];
  initial begin
    ack_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    forever begin
      @(negedge mclk);
      if (!reqN) begin
        repeat (ackDelay) @(negedge mclk);
        ack_n = 1'b0;
        // one low and one high cycle per byte, the minimum spacing
        while (!reqN) begin
          if (dirMode) wr_n = 1'b0;
          else rd_n = 1'b0;
          @(negedge mclk);
          if (!busOe_n) got.push_back(busData);
          rd_n = 1'b1;
          wr_n = 1'b1;
          @(negedge mclk);
        end
        ack_n = 1'b1;
      end
    end
  end
endmodule

// ===== dv/receive_dma_read_channel_bench.sv
// self-checking bench for the receive dma read channel
module receive_dma_read_channel_bench
  import rx_dma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 mclk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 cfgWrite = 1'b0;
  logic [CfgWidth-1:0]  cfgWriteData = 8'h00;
  logic [CfgWidth-1:0]  cfgReadData;
  logic                 msgValid = 1'b0;
  msg_word_t            msgWord = '0;
  logic                 msgReady, req_n, ack_n, rd_n, wr_n, oe_n, waiting;
  logic [ByteWidth-1:0] busData;
  logic                 dirMode = 1'b0;
  logic [3:0]           ackDelay = 4'h0;
  logic [7:0]           exp[$];
  int                   miscompares = 0;
  int                   n_compared = 0;
  int                   cycles = 0;
  receive_dma_read_channel #(.BufDepth(8)) dut (.mclk(mclk), .rst_n(rst_n),
    .cfgWrite(cfgWrite), .cfgWriteData(cfgWriteData),
    .cfgReadData(cfgReadData), .msgValid(msgValid), .msgWord(msgWord),
    .msgReady(msgReady), .read_dma_request_n(req_n),
    .read_dma_acknowledge_n(ack_n), .readStrobe_n(rd_n),
    .writeStrobe_n(wr_n), .busDataOut(busData), .busDataOe_n(oe_n),
    .messageWaiting(waiting));
  dma_ctrl_model dma (.mclk(mclk), .reqN(req_n), .busData(busData),
    .busOe_n(oe_n), .dirMode(dirMode), .ackDelay(ackDelay),
    .ack_n(ack_n), .rd_n(rd_n), .wr_n(wr_n));
  always #25 mclk = ~mclk;
  // a hang stops the run long after the roughly 115 cycles expected
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    n_compared++;
    if (got !== want) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic wcfg(input logic [7:0] v);
    @(negedge mclk);
    cfgWrite = 1'b1;
    cfgWriteData = v;
    @(negedge mclk);
    cfgWrite = 1'b0;
  endtask
  // whole messages are expected out; unfinished ones are flushed later
  task automatic send(input int n, input logic [7:0] b, input logic fin);
    for (int i = 0; i < n; i++) begin
      msgValid = 1'b1;
      msgWord = '{last: fin && i == n - 1, data: b + 8'(i)};
      if (fin) exp.push_back(b + 8'(i));
      while (msgReady !== 1'b1) @(negedge mclk);
      @(negedge mclk);
    end
    msgValid = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  task automatic drain();
    repeat (200) if (dma.got.size() < exp.size()) @(negedge mclk);
    repeat (8) @(negedge mclk);
    chk(8'(dma.got.size()), 8'(exp.size()));
    foreach (exp[i]) chk(dma.got[i], exp[i]);
    dma.got.delete();
    exp.delete();
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk(cfgReadData, CfgResetVal);
    wcfg(8'hFF);
    chk(cfgReadData, 8'hE7);
    wcfg(8'h21);
    send(2, 8'h10, 1'b1);
    chk(8'(req_n), 8'h01);
    chk(8'(waiting), 8'h01);
    wcfg(8'h41);
    repeat (4) @(negedge mclk);
    chk(8'(req_n), 8'h01);
    wcfg(8'h40);
    drain();
    send(3, 8'h30, 1'b0);
    chk(8'(req_n), 8'h01);
    wcfg(8'hC0);
    chk(8'(msgReady), 8'h00);
    wcfg(8'h40);
    send(1, 8'h50, 1'b1);
    drain();
    dirMode = 1'b1;
    ackDelay = 4'h3;
    wcfg(8'h60);
    send(3, 8'h70, 1'b1);
    drain();
    dirMode = 1'b0;
    ackDelay = 4'h0;
    wcfg(8'h40);
    send(2, 8'hA0, 1'b1);
    send(3, 8'hB0, 1'b1);
    drain();
    give_verdict();
  end
endmodule
